// [core/fsp_pkg.sv]
// Shared constants for the sector protection command link.
// Assumes both ends compile against this package.
package fsp_pkg;

    // Opcodes
    localparam logic [7:0] FSP_OP_WREN   = 8'h06;
    localparam logic [7:0] FSP_OP_WRDI   = 8'h04;
    localparam logic [7:0] FSP_OP_PROT   = 8'h36;
    localparam logic [7:0] FSP_OP_UNPROT = 8'h39;

    // Array and frame layout
    localparam int         FSP_NUM_SECT    = 32;
    localparam int         FSP_SECT_W      = 5;
    localparam int         FSP_ADDR_W      = 24;
    localparam int         FSP_SECT_LSB    = 16;
    localparam int         FSP_BYTE_W      = 8;
    localparam int         FSP_WORD_W      = 32;
    localparam int         FSP_BITS_W      = 6;
    localparam int         FSP_POS_W       = 3;
    localparam int         FSP_BCNT_W      = 3;
    localparam logic [2:0] FSP_POS_LAST    = 3'h7;
    localparam logic [2:0] FSP_FRAME_BYTES = 3'h4;

    // Reset values
    localparam logic FSP_PROT_RESET  = 1'b1;
    localparam logic FSP_LATCH_RESET = 1'b0;

    // Host timing in system clock cycles
    localparam int FSP_CNT_W        = 4;
    localparam int FSP_SCK_HALF_CYC = 2;
    localparam int FSP_CS_LEAD_CYC  = 2;
    localparam int FSP_CS_GAP_CYC   = 8;

    typedef enum logic [2:0] {
        FSP_ST_IDLE = 3'b000,
        FSP_ST_LEAD = 3'b001,
        FSP_ST_HI   = 3'b010,
        FSP_ST_LO   = 3'b011,
        FSP_ST_GAP  = 3'b100
    } fsp_host_st_t;

    // Sector index from a byte address; bits below the sector and above the array are ignored
    function automatic logic [FSP_SECT_W-1:0] fsp_sect_idx(input logic [FSP_ADDR_W-1:0] addr);
        fsp_sect_idx = addr[FSP_SECT_LSB +: FSP_SECT_W];
    endfunction

endpackage

// [core/fsp_link_if.sv]
// Serial link between host and flash protection logic.
// Host drives all three wires; the device only listens.
`timescale 1ns/10ps
`default_nettype none
interface fsp_link_if;
    logic sck;
    logic cs_n;
    logic mosi;

    modport host (output sck, output cs_n, output mosi);
    modport dev  (input  sck, input  cs_n, input  mosi);
endinterface
`default_nettype wire

// [core/fsp_dev.sv]
// Device end: frame capture on the serial clock, command execution on sys_clk_i.
// Assumes sck idles while cs_n is high and cs_n stays high for several sys_clk_i cycles.
//
// Contract
// - Opcode 04h frame clears write latch
// - Whole bytes after write-disable opcode ignored
// - Short or misaligned write-disable leaves latch
// - Latch zero refuses guarded commands
// - One protection bit per 64K sector
// - All protection bits one at power-up
// - Bit zero unprotected, one protected
// - Opcode 36h plus three address bytes
// - Valid protect sets bit, clears latch
// - Host sends write-enable before protect
// - Short protect aborts, clears latch
// - Lock set: protect ignored, latch cleared
// - Opcode 39h plus three address bytes
// - Valid unprotect clears bit and latch
// - Short unprotect aborts, clears latch
// - Lock set: unprotect ignored, latch cleared
// - Opcode 06h frame sets write latch
`timescale 1ns/10ps
`default_nettype none
module fsp_dev
    import fsp_pkg::*;
#(
    parameter int NUM_SECT = FSP_NUM_SECT
) (
    input  wire logic                sys_clk_i,
    input  wire logic                rst_i,
    fsp_link_if.dev                  lnk,
    input  wire logic                guard_lock_flag_i,
    output logic                     write_latch_flag_o,
    output logic [NUM_SECT-1:0]      sector_prot_o,
    output logic                     frame_done_o,
    output logic                     cmd_refused_o
);

    // ---------------- Link clock domain ----------------
    logic                    frame_act_reg;
    logic                    frame_tog_reg;
    logic [FSP_POS_W-1:0]    bit_pos_reg;
    logic [FSP_BCNT_W-1:0]   byte_cnt_reg;
    logic [FSP_BYTE_W-1:0]   shift_reg;
    logic [FSP_BYTE_W-1:0]   opcode_reg;
    logic [FSP_ADDR_W-1:0]   addr_reg;
    logic                    lnk_clr_reg;

    logic [FSP_POS_W-1:0]    cur_pos;
    logic [FSP_BCNT_W-1:0]   cur_bytes;
    logic                    byte_done;
    logic [FSP_BYTE_W-1:0]   new_byte;

    // Counts restart at the first edge of each frame
    assign cur_pos   = frame_act_reg ? bit_pos_reg  : '0;
    assign cur_bytes = frame_act_reg ? byte_cnt_reg : '0;
    assign byte_done = (cur_pos == FSP_POS_LAST);
    assign new_byte  = {shift_reg[FSP_BYTE_W-2:0], lnk.mosi};

    // Frame activity, dropped by chip select itself
    always_ff @(posedge lnk.sck or posedge lnk.cs_n) begin
        if (lnk.cs_n) begin
            frame_act_reg <= 1'b0;
        end else begin
            frame_act_reg <= 1'b1;
        end
    end

    // One toggle per frame that saw at least one clock
    always_ff @(posedge lnk.sck or posedge lnk_clr_reg) begin
        if (lnk_clr_reg) begin
            frame_tog_reg <= 1'b0;
        end else if (!frame_act_reg) begin
            frame_tog_reg <= ~frame_tog_reg;
        end
    end

    // Bit and byte position within the frame
    always_ff @(posedge lnk.sck) begin
        bit_pos_reg <= cur_pos + 3'h1;
        shift_reg   <= new_byte;
        if (byte_done && (cur_bytes < FSP_FRAME_BYTES)) begin
            byte_cnt_reg <= cur_bytes + 3'h1;
        end else begin
            byte_cnt_reg <= cur_bytes;
        end
    end

    // Opcode and address capture; bytes past the address are dropped
    always_ff @(posedge lnk.sck) begin
        if (byte_done && (cur_bytes == '0)) begin
            opcode_reg <= new_byte;
        end
        if (byte_done && (cur_bytes != '0) && (cur_bytes < FSP_FRAME_BYTES)) begin
            addr_reg <= {addr_reg[FSP_ADDR_W-FSP_BYTE_W-1:0], new_byte};
        end
    end

    // ---------------- System clock domain ----------------
    logic                    cs_meta_reg;
    logic                    cs_sync_reg;
    logic                    cs_last_reg;
    logic                    tog_meta_reg;
    logic                    tog_sync_reg;
    logic                    tog_seen_reg;
    logic                    latch_reg;
    logic                    latch_next;
    logic [NUM_SECT-1:0]     prot_reg;
    logic                    frame_done_reg;
    logic                    refused_reg;
    logic                    refused_next;
    logic                    prot_set;
    logic                    prot_clr;

    logic                    frame_end;
    logic                    new_frame;
    logic                    aligned;
    logic                    has_opcode;
    logic                    full_addr;
    logic [FSP_SECT_W-1:0]   sect;

    // Held reset for the toggle flop on the link side
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            lnk_clr_reg <= 1'b1;
        end else begin
            lnk_clr_reg <= 1'b0;
        end
    end

    // Two-flop synchronisers
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cs_meta_reg  <= 1'b1;
            cs_sync_reg  <= 1'b1;
            cs_last_reg  <= 1'b1;
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
        end else begin
            cs_meta_reg  <= lnk.cs_n;
            cs_sync_reg  <= cs_meta_reg;
            cs_last_reg  <= cs_sync_reg;
            tog_meta_reg <= frame_tog_reg;
            tog_sync_reg <= tog_meta_reg;
        end
    end

    assign frame_end = cs_sync_reg && !cs_last_reg;
    assign new_frame = frame_end && (tog_sync_reg != tog_seen_reg);

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            tog_seen_reg <= 1'b0;
        end else if (frame_end) begin
            tog_seen_reg <= tog_sync_reg;
        end
    end

    // Link registers are quiet here since sck idles while cs_n is high
    assign aligned    = (bit_pos_reg == '0);
    assign has_opcode = (byte_cnt_reg != '0);
    assign full_addr  = (byte_cnt_reg == FSP_FRAME_BYTES);
    assign sect       = fsp_sect_idx(addr_reg);

    // Command decode at frame end
    always_comb begin
        latch_next   = latch_reg;
        refused_next = 1'b0;
        prot_set     = 1'b0;
        prot_clr     = 1'b0;
        if (new_frame && has_opcode) begin
            case (opcode_reg)
                FSP_OP_WREN: begin
                    if (aligned) begin
                        latch_next = 1'b1;
                    end
                end
                FSP_OP_WRDI: begin
                    if (aligned) begin
                        latch_next = 1'b0;
                    end
                end
                FSP_OP_PROT,
                FSP_OP_UNPROT: begin
                    latch_next = 1'b0;
                    if (aligned && full_addr && latch_reg && !guard_lock_flag_i) begin
                        prot_set = (opcode_reg == FSP_OP_PROT);
                        prot_clr = (opcode_reg == FSP_OP_UNPROT);
                    end else begin
                        refused_next = 1'b1;
                    end
                end
                default: begin
                    latch_next = latch_reg;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            latch_reg <= FSP_LATCH_RESET;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // One flag per sector, all protected out of reset
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            prot_reg <= {NUM_SECT{FSP_PROT_RESET}};
        end else if (prot_set) begin
            prot_reg[sect] <= 1'b1;
        end else if (prot_clr) begin
            prot_reg[sect] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            frame_done_reg <= 1'b0;
            refused_reg    <= 1'b0;
        end else begin
            frame_done_reg <= new_frame;
            refused_reg    <= refused_next;
        end
    end

    assign write_latch_flag_o = latch_reg;
    assign sector_prot_o      = prot_reg;
    assign frame_done_o       = frame_done_reg;
    assign cmd_refused_o      = refused_reg;

endmodule // fsp_dev
`default_nettype wire

// [core/fsp_host.sv]
// Host end: sends one chip-select frame per accepted request, mode 0, MSB first.
// Assumes the device end samples on rising sck and needs a gap between frames.
`timescale 1ns/10ps
`default_nettype none
module fsp_host
    import fsp_pkg::*;
#(
    parameter int SCK_HALF_CYC = FSP_SCK_HALF_CYC,
    parameter int CS_LEAD_CYC  = FSP_CS_LEAD_CYC,
    parameter int CS_GAP_CYC   = FSP_CS_GAP_CYC
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  cmd_valid_i,
    output logic                       cmd_ready_o,
    input  wire logic [FSP_WORD_W-1:0] cmd_word_i,
    input  wire logic [FSP_BITS_W-1:0] cmd_bits_i,
    output logic                       frame_sent_o,
    fsp_link_if.host                   lnk
);

    localparam logic [FSP_CNT_W-1:0] HALF_LOAD = FSP_CNT_W'(SCK_HALF_CYC - 1);
    localparam logic [FSP_CNT_W-1:0] LEAD_LOAD = FSP_CNT_W'(CS_LEAD_CYC - 1);
    localparam logic [FSP_CNT_W-1:0] GAP_LOAD  = FSP_CNT_W'(CS_GAP_CYC - 1);

    fsp_host_st_t            state_reg;
    logic [FSP_CNT_W-1:0]    cnt_reg;
    logic [FSP_WORD_W-1:0]   word_reg;
    logic [FSP_BITS_W-1:0]   bits_reg;
    logic                    sck_reg;
    logic                    cs_n_reg;
    logic                    mosi_reg;
    logic                    sent_reg;
    logic                    tick;

    assign tick        = (cnt_reg == '0);
    assign cmd_ready_o = (state_reg == FSP_ST_IDLE);

    // Frame sequencer; data changes on falling sck, device samples on rising
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            state_reg <= FSP_ST_IDLE;
            cnt_reg   <= '0;
            word_reg  <= '0;
            bits_reg  <= '0;
            sck_reg   <= 1'b0;
            cs_n_reg  <= 1'b1;
            mosi_reg  <= 1'b0;
            sent_reg  <= 1'b0;
        end else begin
            sent_reg <= 1'b0;
            case (state_reg)
                FSP_ST_IDLE: begin
                    if (cmd_valid_i) begin
                        word_reg  <= cmd_word_i;
                        bits_reg  <= cmd_bits_i;
                        mosi_reg  <= cmd_word_i[FSP_WORD_W-1];
                        cs_n_reg  <= 1'b0;
                        cnt_reg   <= LEAD_LOAD;
                        state_reg <= FSP_ST_LEAD;
                    end
                end
                FSP_ST_LEAD: begin
                    if (!tick) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else if (bits_reg == '0) begin
                        cs_n_reg  <= 1'b1;
                        sent_reg  <= 1'b1;
                        cnt_reg   <= GAP_LOAD;
                        state_reg <= FSP_ST_GAP;
                    end else begin
                        sck_reg   <= 1'b1;
                        cnt_reg   <= HALF_LOAD;
                        state_reg <= FSP_ST_HI;
                    end
                end
                FSP_ST_HI: begin
                    if (!tick) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        sck_reg   <= 1'b0;
                        bits_reg  <= bits_reg - 6'h1;
                        word_reg  <= {word_reg[FSP_WORD_W-2:0], 1'b0};
                        mosi_reg  <= word_reg[FSP_WORD_W-2];
                        cnt_reg   <= HALF_LOAD;
                        state_reg <= FSP_ST_LO;
                    end
                end
                FSP_ST_LO: begin
                    if (!tick) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else if (bits_reg == '0) begin
                        cs_n_reg  <= 1'b1;
                        sent_reg  <= 1'b1;
                        cnt_reg   <= GAP_LOAD;
                        state_reg <= FSP_ST_GAP;
                    end else begin
                        sck_reg   <= 1'b1;
                        cnt_reg   <= HALF_LOAD;
                        state_reg <= FSP_ST_HI;
                    end
                end
                FSP_ST_GAP: begin
                    // Device end needs this gap to take the frame over
                    if (!tick) begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end else begin
                        state_reg <= FSP_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= FSP_ST_IDLE;
                end
            endcase
        end
    end

    assign lnk.sck      = sck_reg;
    assign lnk.cs_n     = cs_n_reg;
    assign lnk.mosi     = mosi_reg;
    assign frame_sent_o = sent_reg;

endmodule // fsp_host
`default_nettype wire

// [bench/fsp_link_props.sv]
// Checker for the host-device link and the device's protection outputs.
// Assumes instantiation beside the link interface in the bench top.
`timescale 1ns/10ps
`default_nettype none
module fsp_link_props
    import fsp_pkg::*;
#(
    parameter int NUM_SECT = FSP_NUM_SECT
) (
    input wire logic                sys_clk_i,
    input wire logic                rst_i,
    input wire logic                sck,
    input wire logic                cs_n,
    input wire logic                mosi,
    input wire logic                guard_lock_flag_i,
    input wire logic                write_latch_flag_o,
    input wire logic [NUM_SECT-1:0] sector_prot_o,
    input wire logic                frame_done_o,
    input wire logic                cmd_refused_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_frame_end;
        $rose(cs_n);
    endsequence
    sequence s_applied;
        ##[3:8] frame_done_o;
    endsequence
    sequence s_prot_kept;
        sector_prot_o == $past(sector_prot_o, 2);
    endsequence
    sequence s_applied_now;
        frame_done_o && !write_latch_flag_o;
    endsequence
    sequence s_one_flip;
        $onehot(sector_prot_o ^ $past(sector_prot_o));
    endsequence

    AST_SCK_IDLE: assert property (cs_n |-> !sck)
        else $error("sck active while deselected");
    AST_MOSI_HOLD: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("mosi moved while sck high");
    AST_PROT_RESET: assert property ($past(rst_i) |-> &sector_prot_o)
        else $error("protection bits not all set after reset");
    AST_LATCH_RESET: assert property ($past(rst_i) |-> !write_latch_flag_o)
        else $error("write latch set after reset");
    AST_FRAME_APPLY: assert property (s_frame_end |-> s_applied)
        else $error("no completion after frame end");
    AST_REFUSE_PAIR: assert property (cmd_refused_o |-> frame_done_o)
        else $error("refusal without completion");
    AST_LOCK_HOLD: assert property (frame_done_o && guard_lock_flag_i |-> s_prot_kept)
        else $error("protection changed while locked");
    AST_LATCH_GATE: assert property (frame_done_o && !$past(write_latch_flag_o, 2) |-> s_prot_kept)
        else $error("protection changed with latch clear");
    AST_CHG_CLEARS: assert property ($changed(sector_prot_o) |-> s_applied_now)
        else $error("protection change without latch clear");
    AST_ONE_SECTOR: assert property ($changed(sector_prot_o) |-> s_one_flip)
        else $error("more than one sector changed");
    AST_DONE_PULSE: assert property (frame_done_o |=> !frame_done_o)
        else $error("completion longer than one cycle");
endmodule // fsp_link_props
`default_nettype wire

// [bench/flash_sector_protect_cmds_bench.sv]
// Bench joining host and device ends over the link interface.
// Assumes the fsp_pkg constants and the hand-over timing of both ends.
`timescale 1ns/10ps
`default_nettype none
module flash_sector_protect_cmds_bench
    import fsp_pkg::*;
;
    logic                    sys_clk_i         = 1'b0;
    logic                    rst_i             = 1'b1;
    logic                    cmd_valid_i       = 1'b0;
    logic [FSP_WORD_W-1:0]   cmd_word_i        = '0;
    logic [FSP_BITS_W-1:0]   cmd_bits_i        = '0;
    logic                    guard_lock_flag_i = 1'b0;
    logic                    cmd_ready_o;
    logic                    frame_sent_o;
    logic                    write_latch_flag_o;
    logic                    frame_done_o;
    logic                    cmd_refused_o;
    logic [FSP_NUM_SECT-1:0] sector_prot_o;
    logic [FSP_NUM_SECT-1:0] exp_prot;
    logic                    exp_latch;
    int                      err_count         = 0;
    int                      n_tests           = 0;
    int                      cyc               = 0;

    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    fsp_link_if lnk_if ();
    fsp_host fsp_host_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_word_i(cmd_word_i), .cmd_bits_i(cmd_bits_i),
        .frame_sent_o(frame_sent_o), .lnk(lnk_if.host));
    fsp_dev #(.NUM_SECT(FSP_NUM_SECT)) fsp_dev_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .lnk(lnk_if.dev), .guard_lock_flag_i(guard_lock_flag_i),
        .write_latch_flag_o(write_latch_flag_o), .sector_prot_o(sector_prot_o),
        .frame_done_o(frame_done_o), .cmd_refused_o(cmd_refused_o));
    fsp_link_props #(.NUM_SECT(FSP_NUM_SECT)) fsp_link_props_i (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .sck(lnk_if.sck), .cs_n(lnk_if.cs_n), .mosi(lnk_if.mosi),
        .guard_lock_flag_i(guard_lock_flag_i), .write_latch_flag_o(write_latch_flag_o),
        .sector_prot_o(sector_prot_o), .frame_done_o(frame_done_o),
        .cmd_refused_o(cmd_refused_o));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("Counts: %0d compares, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One frame, expected effects worked out first, then compared after completion
    task automatic send(input logic [7:0] op, input logic [23:0] addr, input int bits);
        logic ref_exp;
        logic whole;
        int   k;
        whole   = (bits % 8 == 0) && (bits >= 8);
        ref_exp = 1'b0;
        if (whole && op == FSP_OP_WREN) exp_latch = 1'b1;
        if (whole && op == FSP_OP_WRDI) exp_latch = 1'b0;
        if (bits >= 8 && (op == FSP_OP_PROT || op == FSP_OP_UNPROT)) begin
            ref_exp = !(whole && bits >= 32 && exp_latch && !guard_lock_flag_i);
            if (!ref_exp) exp_prot[addr[FSP_SECT_LSB +: FSP_SECT_W]] = (op == FSP_OP_PROT);
            exp_latch = 1'b0;
        end
        @(negedge sys_clk_i);
        cmd_word_i  = {op, addr};
        cmd_bits_i  = bits[FSP_BITS_W-1:0];
        cmd_valid_i = 1'b1;
        while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
        check(32'(cmd_ready_o), 32'h0);
        k = 0;
        // Host frame length: lead-in, then two half periods per bit
        while (frame_sent_o !== 1'b1 && k < 1000) begin
            @(negedge sys_clk_i);
            k++;
        end
        check(32'(k), 32'(FSP_CS_LEAD_CYC + 2 * FSP_SCK_HALF_CYC * bits));
        while (frame_done_o !== 1'b1 && k < 1000) begin
            @(negedge sys_clk_i);
            k++;
        end
        check(32'(frame_done_o), 32'h1);
        check(32'(cmd_refused_o), 32'(ref_exp));
        check(32'(write_latch_flag_o), 32'(exp_latch));
        check(sector_prot_o, exp_prot);
    endtask

    task automatic do_reset();
        if (rst_i !== 1'b1) begin
            @(negedge sys_clk_i);
            rst_i = 1'b1;
        end
        repeat (3) @(negedge sys_clk_i);
        rst_i     = 1'b0;
        exp_prot  = '1;
        exp_latch = 1'b0;
        check(sector_prot_o, exp_prot);
        check(32'(write_latch_flag_o), 32'h0);
        repeat (4) @(negedge sys_clk_i);
    endtask

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        do_reset();
        send(FSP_OP_WREN, 24'h0, 8);
        send(FSP_OP_WRDI, 24'h0, 16);
        send(FSP_OP_WREN, 24'h0, 8);
        send(FSP_OP_WRDI, 24'h0, 12);
        send(FSP_OP_WRDI, 24'h0, 5);
        send(FSP_OP_WRDI, 24'h0, 8);
        $display("Test latch done");
        for (int s = 0; s < FSP_NUM_SECT; s += 5) begin
            send(FSP_OP_WREN, 24'h0, 8);
            send(FSP_OP_UNPROT, {3'h7, 5'(s), 16'ha5c3}, (s % 2) ? 40 : 32);
        end
        $display("Test unprotect done");
        send(FSP_OP_PROT, 24'h000000, 32);
        send(FSP_OP_WREN, 24'h0, 8);
        send(FSP_OP_PROT, 24'h050000, 24);
        send(FSP_OP_WREN, 24'h0, 8);
        send(FSP_OP_UNPROT, 24'h010000, 36);
        $display("Test abort done");
        @(negedge sys_clk_i);
        guard_lock_flag_i = 1'b1;
        send(FSP_OP_WREN, 24'h0, 8);
        send(FSP_OP_PROT, 24'h0a0000, 32);
        send(FSP_OP_WREN, 24'h0, 8);
        send(FSP_OP_UNPROT, 24'h010000, 32);
        @(negedge sys_clk_i);
        guard_lock_flag_i = 1'b0;
        $display("Test lock done");
        send(FSP_OP_WREN, 24'h0, 8);
        send(FSP_OP_PROT, 24'h00ffff, 32);
        send(FSP_OP_WREN, 24'h0, 8);
        send(FSP_OP_PROT, 24'h1e0000, 40);
        $display("Test protect done");
        send(FSP_OP_WREN, 24'h0, 8);
        send(8'hc3, 24'h030000, 32);
        send(FSP_OP_UNPROT, 24'h030000, 32);
        do_reset();
        $display("Test second reset done");
        final_report();
    end
endmodule // flash_sector_protect_cmds_bench
`default_nettype wire
